// *** rtl/smw_regs.svh ***
// Purpose : Named constants of the static memory wait-state control.
// Assumes : Included by the design module, the monitor and the bench.
// Notes   : Counts are in master clock cycles.
`ifndef SMW_REGS_SVH
`define SMW_REGS_SVH

// -----------------------------------------------------------------
// Sizes and wait modes
// -----------------------------------------------------------------
`define SMW_NUM_CS        8
`define SMW_WAIT_OFF      2'h0
`define SMW_WAIT_FROZEN   2'h2
`define SMW_WAIT_READY    2'h3
`define SMW_CNT_ZERO      8'h00
`define SMW_CNT_ONE       8'h01
`define SMW_TDF_ZERO      4'h0
`define SMW_TDF_ONE       4'h1
`define SMW_CS_IDLE       8'hff
`define SMW_CS_ONE_HOT    8'h01

// -----------------------------------------------------------------
// Fixed waveforms while the master clock runs very slowly
// -----------------------------------------------------------------
`define SMW_SLOW_RD_SETUP 8'h01
`define SMW_SLOW_RD_PULSE 8'h01
`define SMW_SLOW_RD_HOLD  8'h00
`define SMW_SLOW_WR_SETUP 8'h01
`define SMW_SLOW_WR_PULSE 8'h01
`define SMW_SLOW_WR_HOLD  8'h01

`endif

// *** rtl/smw_pkg.sv ***
// Purpose : Types of the static memory wait-state control.
// Assumes : Nothing beyond the constants header.
// Notes   : Timing fields hold effective cycle counts.
package smw_pkg;

  // -----------------------------------------------------------------
  // Per chip select configuration
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] rd_setup;
    logic [7:0] rd_pulse;
    logic [7:0] rd_hold;
    logic [7:0] wr_setup;
    logic [7:0] wr_pulse;
    logic [7:0] wr_hold;
    logic       read_mode;
    logic       tdf_mode;
    logic [3:0] tdf_cycles;
    logic [1:0] ext_wait_mode;
  } smw_cfg_t;

  typedef struct packed {
    logic [7:0] setup;
    logic [7:0] pulse;
    logic [7:0] hold;
  } smw_tim_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic       internal;
    logic [2:0] cs;
  } smw_req_t;

  typedef enum logic [2:0] {
    SMW_IDLE    = 3'h0,
    SMW_RELOAD  = 3'h1,
    SMW_FLOAT   = 3'h3,
    SMW_SETUP   = 3'h2,
    SMW_PULSE   = 3'h6,
    SMW_HOLD    = 3'h7,
    SMW_SUSPEND = 3'h4
  } smw_state_t;

endpackage

// *** rtl/smw_static_mem_wait.sv ***
// Purpose : Access sequencer with data float, external wait and slow clock waveforms.
// Assumes : Requester holds off new external requests while busy is high.
// Notes   : Internal requests are answered on the next enabled cycle in any state.
`timescale 1ns/10ps
`include "smw_regs.svh"

module smw_static_mem_wait
  import smw_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire smw_cfg_t   cs_cfg [`SMW_NUM_CS],
  input  wire smw_req_t   req,
  input  wire logic       slow_clk_ind,
  input  wire logic       ext_wait_n,
  output logic [7:0]      chip_select_n,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            ext_ack,
  output logic            int_ack,
  output logic            busy
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic smw_tim_t sel_timing(input smw_cfg_t c, input logic wr,
                                          input logic slow);
    smw_tim_t t;
    if (slow) begin
      t.setup = wr ? `SMW_SLOW_WR_SETUP : `SMW_SLOW_RD_SETUP;
      t.pulse = wr ? `SMW_SLOW_WR_PULSE : `SMW_SLOW_RD_PULSE;
      t.hold  = wr ? `SMW_SLOW_WR_HOLD  : `SMW_SLOW_RD_HOLD;
    end else begin
      t.setup = wr ? c.wr_setup : c.rd_setup;
      t.pulse = wr ? c.wr_pulse : c.rd_pulse;
      t.hold  = wr ? c.wr_hold  : c.rd_hold;
    end
    return t;
  endfunction

  function automatic logic [7:0] dec(input logic [7:0] v);
    return 8'(v - `SMW_CNT_ONE);
  endfunction

  // -----------------------------------------------------------------
  // Wait input synchroniser
  // -----------------------------------------------------------------
  logic wait_meta_r, wait_meta_nxt;
  logic wait_sync_r, wait_sync_nxt;

  always_comb begin
    wait_meta_nxt = ext_wait_n;
    wait_sync_nxt = wait_meta_r;
  end

  // The pin idles high through its pull-up, so both stages reset released.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wait_meta_r <= 1'b1;
      wait_sync_r <= 1'b1;
    end else if (clk_en) begin
      wait_meta_r <= wait_meta_nxt;
      wait_sync_r <= wait_sync_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Sequencer state
  // -----------------------------------------------------------------
  smw_state_t state_r,  state_nxt;
  logic [7:0] cnt_r,    cnt_nxt;
  logic [2:0] cur_cs_r, cur_cs_nxt;
  logic       cur_wr_r, cur_wr_nxt;
  logic       use_slow_r, use_slow_nxt;
  logic       slow_seen_r, slow_seen_nxt;
  logic [2:0] last_cs_r, last_cs_nxt;
  logic       last_opt_r, last_opt_nxt;
  logic [7:0] float_rem_r, float_rem_nxt;
  logic [7:0] cs_n_r,   cs_n_nxt;
  logic       rd_n_r,   rd_n_nxt;
  logic       wr_n_r,   wr_n_nxt;
  logic       ext_ack_r, ext_ack_nxt;
  logic       int_ack_r, int_ack_nxt;
  logic       busy_r,   busy_nxt;

  smw_cfg_t   cfg;
  smw_tim_t   tim;
  logic       wait_act;
  logic       end_pulse;
  logic       finish;
  logic       float_need;
  logic [7:0] cs_sel_n;
  logic [3:0] tdf_left;

  always_comb begin
    cfg           = cs_cfg[cur_cs_r];
    tim           = sel_timing(cfg, cur_wr_r, use_slow_r);
    wait_act      = !wait_sync_r && !use_slow_r;
    cs_sel_n      = ~8'(`SMW_CS_ONE_HOT << cur_cs_r);
    end_pulse     = 1'b0;
    finish        = 1'b0;
    tdf_left      = `SMW_TDF_ZERO;
    state_nxt     = state_r;
    cnt_nxt       = cnt_r;
    cur_cs_nxt    = cur_cs_r;
    cur_wr_nxt    = cur_wr_r;
    use_slow_nxt  = use_slow_r;
    slow_seen_nxt = slow_seen_r;
    last_cs_nxt   = last_cs_r;
    last_opt_nxt  = last_opt_r;
    float_rem_nxt = float_rem_r;
    cs_n_nxt      = cs_n_r;
    rd_n_nxt      = rd_n_r;
    wr_n_nxt      = wr_n_r;
    ext_ack_nxt   = 1'b0;
    int_ack_nxt   = req.valid && req.internal;
    // Float time elapses in every state but SMW_SUSPEND and a frozen waited pulse, so idle gaps shorten later waits.
    if (float_rem_r != `SMW_CNT_ZERO && state_r != SMW_SUSPEND &&
        !(state_r == SMW_PULSE && cfg.ext_wait_mode == `SMW_WAIT_FROZEN && wait_act)) begin
      float_rem_nxt = dec(float_rem_r);
    end
    float_need = float_rem_r != `SMW_CNT_ZERO &&
                 (cur_wr_r || cur_cs_r != last_cs_r);
    unique case (state_r)
      SMW_IDLE: begin
        if (req.valid && !req.internal) begin
          cur_cs_nxt   = req.cs;
          cur_wr_nxt   = req.write;
          use_slow_nxt = slow_clk_ind;
          if (slow_clk_ind != slow_seen_r) begin
            slow_seen_nxt = slow_clk_ind;
            state_nxt     = SMW_RELOAD;
          end else begin
            state_nxt = SMW_FLOAT;
          end
        end
      end
      SMW_RELOAD: begin
        state_nxt = SMW_FLOAT;
      end
      SMW_FLOAT: begin
        // The setup credit applies only when the previous read asked for it.
        if (!float_need || (last_opt_r && float_rem_r <= tim.setup)) begin
          cs_n_nxt = cs_sel_n;
          if (tim.setup != `SMW_CNT_ZERO) begin
            state_nxt = SMW_SETUP;
            cnt_nxt   = tim.setup;
          end else begin
            state_nxt = SMW_PULSE;
            cnt_nxt   = tim.pulse;
            rd_n_nxt  = cur_wr_r;
            wr_n_nxt  = !cur_wr_r;
          end
        end
      end
      SMW_SETUP: begin
        if (cnt_r == `SMW_CNT_ONE) begin
          state_nxt = SMW_PULSE;
          cnt_nxt   = tim.pulse;
          rd_n_nxt  = cur_wr_r;
          wr_n_nxt  = !cur_wr_r;
        end else begin
          cnt_nxt = dec(cnt_r);
        end
      end
      SMW_PULSE: begin
        if (cfg.ext_wait_mode == `SMW_WAIT_FROZEN && wait_act) begin
          cnt_nxt = cnt_r;
        end else if (cnt_r == `SMW_CNT_ONE) begin
          if (cfg.ext_wait_mode == `SMW_WAIT_READY && wait_act) begin
            state_nxt = SMW_SUSPEND;
          end else begin
            end_pulse = 1'b1;
          end
        end else begin
          cnt_nxt = dec(cnt_r);
        end
      end
      SMW_SUSPEND: begin
        // Only the release of the synchronised wait ends a suspended pulse.
        end_pulse = !wait_act;
      end
      SMW_HOLD: begin
        if (cnt_r == `SMW_CNT_ONE) begin
          finish = 1'b1;
        end else begin
          cnt_nxt = dec(cnt_r);
        end
      end
      default: begin
        state_nxt = SMW_IDLE;
        cs_n_nxt  = `SMW_CS_IDLE;
        rd_n_nxt  = 1'b1;
        wr_n_nxt  = 1'b1;
      end
    endcase
    if (end_pulse) begin
      rd_n_nxt = 1'b1;
      wr_n_nxt = 1'b1;
      if (tim.hold != `SMW_CNT_ZERO) begin
        state_nxt = SMW_HOLD;
        cnt_nxt   = tim.hold;
      end else begin
        finish = 1'b1;
      end
    end
    if (finish) begin
      state_nxt   = SMW_IDLE;
      cs_n_nxt    = `SMW_CS_IDLE;
      ext_ack_nxt = 1'b1;
      if (!cur_wr_r) begin
        last_cs_nxt  = cur_cs_r;
        last_opt_nxt = cfg.tdf_mode;
        // Strobe-controlled float started at the strobe rise, so the hold
        // cycles already spent are taken off what remains.
        if (cfg.read_mode && !use_slow_r) begin
          if (tim.hold >= 8'(cfg.tdf_cycles)) begin
            tdf_left = `SMW_TDF_ZERO;
          end else begin
            tdf_left = 4'(8'(cfg.tdf_cycles) - tim.hold);
          end
        end else begin
          tdf_left = cfg.tdf_cycles;
        end
        float_rem_nxt = 8'(tdf_left);
      end
    end
    busy_nxt = state_nxt != SMW_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r     <= SMW_IDLE;
      cnt_r       <= `SMW_CNT_ZERO;
      cur_cs_r    <= 3'h0;
      cur_wr_r    <= 1'b0;
      use_slow_r  <= 1'b0;
      slow_seen_r <= 1'b0;
      last_cs_r   <= 3'h0;
      last_opt_r  <= 1'b0;
      float_rem_r <= `SMW_CNT_ZERO;
      cs_n_r      <= `SMW_CS_IDLE;
      rd_n_r      <= 1'b1;
      wr_n_r      <= 1'b1;
      ext_ack_r   <= 1'b0;
      int_ack_r   <= 1'b0;
      busy_r      <= 1'b0;
    end else if (clk_en) begin
      state_r     <= state_nxt;
      cnt_r       <= cnt_nxt;
      cur_cs_r    <= cur_cs_nxt;
      cur_wr_r    <= cur_wr_nxt;
      use_slow_r  <= use_slow_nxt;
      slow_seen_r <= slow_seen_nxt;
      last_cs_r   <= last_cs_nxt;
      last_opt_r  <= last_opt_nxt;
      float_rem_r <= float_rem_nxt;
      cs_n_r      <= cs_n_nxt;
      rd_n_r      <= rd_n_nxt;
      wr_n_r      <= wr_n_nxt;
      ext_ack_r   <= ext_ack_nxt;
      int_ack_r   <= int_ack_nxt;
      busy_r      <= busy_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign chip_select_n  = cs_n_r;
  assign read_strobe_n  = rd_n_r;
  assign write_strobe_n = wr_n_r;
  assign ext_ack        = ext_ack_r;
  assign int_ack        = int_ack_r;
  assign busy           = busy_r;

endmodule

// *** sim/smw_wait_monitor.sv ***
// Purpose : Port checks of the wait-state control.
// Assumes : Clock enable held high, so pin delay equals clock delay.
// Notes   : Synchronised wait is the pin two cycles back.
`timescale 1ns/10ps
`include "smw_regs.svh"
module smw_wait_monitor
  import smw_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire smw_cfg_t   cs_cfg [`SMW_NUM_CS],
  input wire smw_req_t   req,
  input wire logic       slow_clk_ind,
  input wire logic       ext_wait_n,
  input wire logic [7:0] chip_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       ext_ack,
  input wire logic       int_ack,
  input wire logic       busy
);
  logic [1:0] mode;
  logic       strb;
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  always_comb begin
    mode = `SMW_WAIT_OFF;
    strb = !(read_strobe_n && write_strobe_n);
    for (int i = 0; i < `SMW_NUM_CS; i++) begin
      if (!chip_select_n[i]) mode = cs_cfg[i].ext_wait_mode;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_int_ack; req.valid && req.internal |=> int_ack; endproperty
  a_int_ack: assert property (p_int_ack) else $error("internal request unanswered");
  property p_ack_idle; ext_ack |-> chip_select_n == `SMW_CS_IDLE && !busy ##1 !ext_ack;
  endproperty
  a_ack_idle: assert property (p_ack_idle) else $error("select held at acknowledge");
  property p_strobe_cs; strb |-> chip_select_n != `SMW_CS_IDLE; endproperty
  a_strobe_cs: assert property (p_strobe_cs) else $error("strobe outside select");
  property p_slow_rd; $fell(read_strobe_n) && slow_clk_ind && $past(slow_clk_ind, 3)
    |=> read_strobe_n && chip_select_n == `SMW_CS_IDLE; endproperty
  a_slow_rd: assert property (p_slow_rd) else $error("slow read shape wrong");
  property p_slow_wr; $fell(write_strobe_n) && slow_clk_ind && $past(slow_clk_ind, 3)
    |=> write_strobe_n && chip_select_n != `SMW_CS_IDLE ##1 chip_select_n == `SMW_CS_IDLE;
  endproperty
  a_slow_wr: assert property (p_slow_wr) else $error("slow write shape wrong");
  property p_busy_end; $rose(busy) |-> ##[2:200] ext_ack; endproperty
  a_busy_end: assert property (p_busy_end) else $error("access never ends");
  property p_frozen; strb && mode == `SMW_WAIT_FROZEN && !$past(ext_wait_n, 2)
    |=> $stable(chip_select_n) && $stable(read_strobe_n) && $stable(write_strobe_n);
  endproperty
  a_frozen: assert property (p_frozen) else $error("outputs moved while frozen");
  property p_ready; strb && mode == `SMW_WAIT_READY && !$past(ext_wait_n, 2) |=> strb;
  endproperty
  a_ready: assert property (p_ready) else $error("strobe released while waited");
endmodule

// *** sim/smw_mem_model.sv ***
// Purpose : External memory that answers strobes with its wait pin.
// Assumes : Pin has a pull-up, so released means high.
// Notes   : Wait starts wait_lat + 1 cycles after a strobe falls, and no sooner than two.
`timescale 1ns/10ps
module smw_mem_model (
  input  wire logic       core_clk,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic [7:0] wait_lat,
  input  wire logic [7:0] wait_len,
  output logic            ext_wait_n
);
  logic       act_r = 1'b0;
  logic [7:0] cnt_r = 8'h00;
  initial ext_wait_n = 1'b1;
  always @(posedge core_clk) begin
    act_r <= !(read_strobe_n && write_strobe_n);
    if (!(read_strobe_n && write_strobe_n) && !act_r) cnt_r <= 8'h01;
    else if (cnt_r != 8'h00 && cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
    ext_wait_n <= !(cnt_r != 8'h00 && cnt_r >= wait_lat && cnt_r < wait_lat + wait_len);
  end
endmodule

// *** sim/smw_static_mem_wait_tb.sv ***
// Purpose : Self-checking bench of the wait-state control.
// Assumes : Memory model drives the wait pin.
// Notes   : Lengths run from request edge to acknowledge sample.
`timescale 1ns/10ps
`include "smw_regs.svh"
module smw_static_mem_wait_tb;
  import smw_pkg::*;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic       clk_en = 1'b1;
  logic       slow_clk_ind = 1'b0;
  logic       ext_wait_n, read_strobe_n, write_strobe_n, ext_ack, int_ack, busy;
  logic [7:0] chip_select_n, wait_lat = 8'h00, wait_len = 8'h04;
  logic [1:0] wm [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2, 2'h3};
  logic [7:0] wl [6] = '{8'h00, 8'h00, 8'h06, 8'h06, 8'h00, 8'h00};
  smw_cfg_t   cfg [`SMW_NUM_CS];
  smw_req_t   req = '0;
  int         fail_count = 0, samples_checked = 0, cyc = 0, t0, a, b, r, lens[$], exp_q[$];
  // ------------------------------------------------------------
  // Clock, design and far side
  // ------------------------------------------------------------
  always #50 core_clk = ~core_clk;
  smw_static_mem_wait i_smw_static_mem_wait (.core_clk, .reset, .clk_en, .cs_cfg(cfg), .req,
    .slow_clk_ind, .ext_wait_n, .chip_select_n, .read_strobe_n, .write_strobe_n, .ext_ack,
    .int_ack, .busy);
  smw_mem_model i_smw_mem_model (.core_clk, .read_strobe_n, .write_strobe_n, .wait_lat,
    .wait_len, .ext_wait_n);
  function automatic smw_cfg_t mk(input int s, p, h, input logic rm, om, input logic [3:0] t,
                                  input logic [1:0] w);
    return '{s[7:0], p[7:0], h[7:0], 8'h03, p[7:0], h[7:0], rm, om, t, w};
  endfunction
  function automatic int base(input logic [2:0] c, input logic wr);
    return 3 + (wr ? cfg[c].wr_setup + cfg[c].wr_pulse + cfg[c].wr_hold
                   : cfg[c].rd_setup + cfg[c].rd_pulse + cfg[c].rd_hold);
  endfunction
  task automatic check(input int seen, input int want);
    samples_checked++;
    if (seen != want) begin
      fail_count++;
      $display("unexpected at %0t: got %0d, wanted %0d", $time, seen, want);
    end
  endtask
  task automatic stop_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic idle();
    repeat (20) @(posedge core_clk);
  endtask
  // Internal traffic runs during every external access, float included.
  // A low clock enable before the capture edge delays the access by frz cycles.
  task automatic acc(input logic [2:0] c, input logic wr, input int e, input logic drop = 1'b0,
                     input int frz = 0);
    @(posedge core_clk);
    req <= '{1'b1, wr, 1'b0, c};
    t0 = cyc;
    exp_q.push_back(e);
    if (frz > 0) begin
      clk_en <= 1'b0;
      repeat (frz) @(posedge core_clk);
      clk_en <= 1'b1;
    end
    @(posedge core_clk);
    req <= '{1'b1, 1'b0, 1'b1, c};
    if (drop) slow_clk_ind <= 1'b0;
    repeat (300) if (exp_q.size() > 0) @(posedge core_clk);
    req <= '0;
  endtask
  task automatic pair(input logic [2:0] c, input logic wr, output int len);
    idle();
    acc(3'h1, 1'b0, base(3'h1, 1'b0));
    acc(c, wr, -1);
    len = lens[$];
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ext_ack === 1'b1 && exp_q.size() > 0) begin
      lens.push_back(cyc - t0);
      if (exp_q[0] >= 0) check(cyc - t0, exp_q[0]);
      void'(exp_q.pop_front());
    end
    if (cyc == 30000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    r = $urandom(36912);
    for (int i = 0; i < `SMW_NUM_CS; i++) cfg[i] = mk(1, 2, 1, 0, 0, 4'h0, 2'h0);
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    cfg[1] <= mk(1, 2, 1, 0, 0, 4'hf, 2'h0);
    pair(3'h1, 1'b1, a);
    cfg[1] <= mk(1, 2, 1, 0, 0, 4'h8, 2'h0);
    pair(3'h1, 1'b1, b);
    check(a - b, 7);
    cfg[1] <= mk(1, 2, 1, 1, 0, 4'hf, 2'h0);
    pair(3'h1, 1'b1, b);
    check(a - b, 1);
    cfg[1] <= mk(1, 2, 1, 0, 1, 4'hf, 2'h0);
    pair(3'h1, 1'b1, b);
    check(a - b, 3);
    cfg[1] <= mk(1, 2, 1, 0, 0, 4'hf, 2'h0);
    pair(3'h2, 1'b0, a);
    cfg[1] <= mk(1, 2, 1, 0, 0, 4'h8, 2'h0);
    pair(3'h2, 1'b0, b);
    check(a - b, 7);
    pair(3'h1, 1'b0, a);
    check(a, base(3'h1, 1'b0));
    for (int i = 0; i < 6; i++) begin
      cfg[3] <= mk(1, 5, 1, 0, 0, 4'h0, wm[i]);
      wait_lat <= wl[i];
      idle();
      acc(3'h3, 1'b0, i < 4 ? base(3'h3, 1'b0) : -1);
    end
    check(int'(lens[$ - 1] > base(3'h3, 1'b0)), 1);
    check(int'(lens[$] > base(3'h3, 1'b0)), 1);
    acc(3'h1, 1'b0, base(3'h1, 1'b0) + 4, 1'b0, 4);
    slow_clk_ind <= 1'b1;
    idle();
    acc(3'h0, 1'b0, 6);
    acc(3'h0, 1'b0, 5);
    acc(3'h0, 1'b1, 6);
    acc(3'h0, 1'b0, 5, 1'b1);
    acc(3'h0, 1'b0, base(3'h0, 1'b0) + 1);
    for (int i = 0; i < 6; i++) begin
      r = $urandom;
      cfg[r[2:0]] <= mk(1 + r[4:3], 1 + r[6:5], 1 + r[7], r[8], r[9], r[13:10], 2'h0);
      idle();
      acc(r[2:0], r[14], base(r[2:0], r[14]));
    end
    check(exp_q.size(), 0);
    stop_test();
  end
endmodule
bind smw_static_mem_wait smw_wait_monitor i_smw_wait_monitor (.core_clk, .reset, .cs_cfg,
  .req, .slow_clk_ind, .ext_wait_n, .chip_select_n, .read_strobe_n, .write_strobe_n,
  .ext_ack, .int_ack, .busy);
